/* sfrpx_core_model.sv */
// Core-side model issuing data-memory accesses to the decoder
// Assumes the bench calls its tasks one after another from one process
`timescale 1ns/1ps
module sfrpx_core_model (
  // Clock
  input wire logic clock_i,
  // Access request
  output logic valid_o,
  output logic direct_o,
  output logic write_o,
  output logic bit_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial begin
    {valid_o, direct_o, write_o, bit_o, addr_o, wdata_o} = '0;
  end

  ////////////////////////////////////////
  // An access stays on the bus, repeated each cycle, until the next access or release_bus
  task automatic access(input logic dir, input logic wr, input logic bt, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    {valid_o, direct_o, write_o, bit_o, addr_o, wdata_o} <= {1'b1, dir, wr, bt, a, d};
    #1;
  endtask

  // On release, valid_o, write_o and bit_o are driven low and addr_o and wdata_o invert; direct_o keeps its last value
  task automatic release_bus();
    @(negedge clock_i);
    {valid_o, write_o, bit_o} <= 3'b000;
    addr_o <= ~addr_o;
    wdata_o <= ~wdata_o;
  endtask
endmodule // sfrpx_core_model

/* sfrpx_map.sv */
// Page-map lookup: classifies a register address on page 0x0 and page 0xF
// Assumes address already known to lie in 0x80..0xFF
`timescale 1ns/1ps
module sfrpx_map (
  // Lookup
  input wire logic [7:0] addr_i,
  output logic common_o,
  output logic on_pg0_o,
  output logic on_pgf_o
);
  import sfrpx_pkg::*;

  always_comb begin
    common_o = 1'b0;
    on_pg0_o = 1'b1;
    on_pgf_o = 1'b0;
    // Registers present identically on every page
    unique case (addr_i)
      8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h90, 8'hA0, 8'hA7, 8'hA8, 8'hA9,
      8'hD0, 8'hE0, 8'hE6, 8'hE7, 8'hF0: begin
        common_o = 1'b1; // [RULE10]
      end
      default: begin
      end
    endcase
    // Registers present on page 0xF; these addresses also decode on page 0x0
    unique case (addr_i)
      8'h85, 8'h86, 8'h91, 8'h92, 8'h93, 8'h95, 8'h96, 8'h97, 8'hA4, 8'hA5,
      8'hA6, 8'hBA, 8'hBD, 8'hF6, 8'hF7: begin
        on_pgf_o = 1'b1; // [RULE11]
      end
      default: begin
      end
    endcase
    // Holes on page 0x0
    unique case (addr_i)
      8'hAB, 8'hAF, 8'hB4, 8'hE5: begin
        on_pg0_o = 1'b0; // [RULE18]
      end
      default: begin
      end
    endcase
  end

endmodule // sfrpx_map

/* sfrpx_pkg.sv */
// Constants and types for the special-function-register page decoder
// Assumes a single core clock with synchronous active-low reset
// How it works
// RULE1: XRAM page register bits 7:4 read zero; writes to them are dropped.
// RULE2: Eight-bit external move takes its high address byte from the XRAM page register.
// RULE3: Only the four page bits feed the high byte; sixteen pages exist.
// RULE4: XRAM page register lives at 0xAA on page 0x0, reset to zero.
// RULE5: Direct accesses to 0x80..0xFF go to register space, not internal RAM.
// RULE6: Addresses with low nibble 0x0 or 0x8 allow bit access; others byte only.
// RULE7: Software must not touch unoccupied register locations.
// RULE8: Each register address is qualified by the current page select value.
// RULE9: Accesses target page 0x0 unless software selects another page.
// RULE10: Core registers, page select included, decode the same on every page.
// RULE11: With page 0xF selected, page-0xF registers replace page-0x0 ones.
// RULE12: Software saves interrupt enable, disables, uses page 0xF, then restores.
// RULE13: Eight-bit external move takes its low address byte from R0 or R1.
// RULE14: Sixteen-bit external move uses the data pointer, ignoring the page register.
// RULE15: Indirect accesses above 0x7F reach upper internal RAM, never registers.
// RULE16: Page select sits at 0xA7 on all pages, eight bits, resets to zero.
// RULE17: A page-select write applies to the very next register access.
// RULE18: Unmapped locations read zero and ignore writes.
package sfrpx_pkg;

  localparam logic [7:0] SFRPX_SFR_BASE = 8'h80;
  localparam logic [7:0] SFRPX_ADDR_PAGE_SEL = 8'hA7;
  localparam logic [7:0] SFRPX_ADDR_XRAM_PAGE = 8'hAA;
  localparam logic [7:0] SFRPX_PAGE_DEFAULT = 8'h00;
  localparam logic [7:0] SFRPX_PAGE_EXTRA = 8'h0F;
  localparam logic [7:0] SFRPX_PAGE_SEL_RESET = 8'h00;
  localparam logic [7:0] SFRPX_XRAM_PAGE_RESET = 8'h00;
  localparam int SFRPX_XRAM_FIELD_MSB = 3;
  localparam logic [3:0] SFRPX_BIT_NIB_A = 4'h0;
  localparam logic [3:0] SFRPX_BIT_NIB_B = 4'h8;

  // Where a direct access lands
  typedef enum logic [1:0] {
    SFRPX_TGT_NONE = 2'b00,
    SFRPX_TGT_ALL = 2'b01,
    SFRPX_TGT_PG0 = 2'b10,
    SFRPX_TGT_PGF = 2'b11
  } sfrpx_tgt_type;

  // Page residency of one address on the two implemented pages
  typedef enum logic [1:0] {
    SFRPX_MAP_NONE = 2'b00,
    SFRPX_MAP_ALL = 2'b01,
    SFRPX_MAP_P0 = 2'b10,
    SFRPX_MAP_BOTH = 2'b11
  } sfrpx_map_type;

endpackage

/* sfrpx_top.sv */
// Register-page decoder with page select and XRAM page register
// Assumes the core drives one access per cycle, synchronous to CLOCK_I
`timescale 1ns/1ps
module sfrpx_top (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // Data-memory access from the core
  input wire logic ACC_VALID_I,
  input wire logic ACC_DIRECT_I,
  input wire logic ACC_WRITE_I,
  input wire logic ACC_BIT_I,
  input wire logic [7:0] ACC_ADDR_I,
  input wire logic [7:0] ACC_WDATA_I,
  // Decode results
  output logic SFR_SEL_O,
  output logic IRAM_SEL_O,
  output logic [1:0] SFR_TARGET_O,
  output logic [7:0] SFR_PAGE_O,
  output logic BIT_OK_O,
  output logic [7:0] RDATA_O,
  output logic RDATA_HIT_O,
  // External move
  input wire logic XMOVE_SHORT_I,
  input wire logic XMOVE_USE_R1_I,
  input wire logic [7:0] XMOVE_R0_I,
  input wire logic [7:0] XMOVE_R1_I,
  input wire logic [15:0] XMOVE_DATA_POINTER_I,
  output logic [15:0] XMOVE_ADDR_O
);
  import sfrpx_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Decode
  logic in_sfr;
  logic common;
  logic on_pg0;
  logic on_pgf;
  logic [7:0] page_sel_reg;
  logic [7:0] page_sel_next;
  logic [3:0] xram_page_reg;
  logic [3:0] xram_page_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic hit_reg;
  logic hit_next;
  logic [7:0] xindex;
  sfrpx_tgt_type tgt;

  assign in_sfr = ACC_VALID_I && ACC_DIRECT_I && ACC_ADDR_I[7]; // [RULE5] [RULE15]

  sfrpx_map u_map (
    .addr_i(ACC_ADDR_I),
    .common_o(common),
    .on_pg0_o(on_pg0),
    .on_pgf_o(on_pgf)
  );

  // Live page value in the decode path is the register itself
  always_comb begin
    tgt = SFRPX_TGT_NONE;
    if (in_sfr) begin
      if (common) begin
        tgt = SFRPX_TGT_ALL; // [RULE10] [RULE16]
      end else if (page_sel_reg == SFRPX_PAGE_EXTRA) begin
        if (on_pgf) begin
          tgt = SFRPX_TGT_PGF; // [RULE8] [RULE11]
        end
      end else if (page_sel_reg == SFRPX_PAGE_DEFAULT) begin
        if (on_pg0) begin
          tgt = SFRPX_TGT_PG0; // [RULE9]
        end
      end
    end
  end

  assign SFR_SEL_O = in_sfr;
  assign IRAM_SEL_O = ACC_VALID_I && !in_sfr; // [RULE15]
  assign SFR_TARGET_O = tgt;
  assign SFR_PAGE_O = page_sel_reg;
  assign BIT_OK_O = in_sfr && (ACC_ADDR_I[3:0] == SFRPX_BIT_NIB_A
    || ACC_ADDR_I[3:0] == SFRPX_BIT_NIB_B); // [RULE6]

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_comb begin
    page_sel_next = page_sel_reg;
    xram_page_next = xram_page_reg;
    rdata_next = 8'h00;
    hit_next = 1'b0;
    if (in_sfr && ACC_WRITE_I && !ACC_BIT_I) begin
      if (ACC_ADDR_I == SFRPX_ADDR_PAGE_SEL) begin
        page_sel_next = ACC_WDATA_I; // [RULE16] [RULE17]
      end else if (ACC_ADDR_I == SFRPX_ADDR_XRAM_PAGE && tgt == SFRPX_TGT_PG0) begin
        xram_page_next = ACC_WDATA_I[SFRPX_XRAM_FIELD_MSB:0]; // [RULE1] [RULE4]
      end
    end else if (in_sfr && !ACC_WRITE_I) begin
      if (ACC_ADDR_I == SFRPX_ADDR_PAGE_SEL) begin
        rdata_next = page_sel_reg;
        hit_next = 1'b1;
      end else if (ACC_ADDR_I == SFRPX_ADDR_XRAM_PAGE && tgt == SFRPX_TGT_PG0) begin
        rdata_next = {4'h0, xram_page_reg}; // [RULE1]
        hit_next = 1'b1;
      end
      // Anything else in this block reads zero [RULE18]
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      page_sel_reg <= SFRPX_PAGE_SEL_RESET; // [RULE16]
      xram_page_reg <= SFRPX_XRAM_PAGE_RESET[SFRPX_XRAM_FIELD_MSB:0]; // [RULE4]
      rdata_reg <= 8'h00;
      hit_reg <= 1'b0;
    end else begin
      page_sel_reg <= page_sel_next;
      xram_page_reg <= xram_page_next;
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
    end
  end

  assign RDATA_O = rdata_reg;
  assign RDATA_HIT_O = hit_reg;

  ////////////////////////////////////////////////////////////////////////
  // External move address
  assign xindex = XMOVE_USE_R1_I ? XMOVE_R1_I : XMOVE_R0_I; // [RULE13]

  sfrpx_xaddr u_xaddr (
    .short_form_i(XMOVE_SHORT_I),
    .index_i(xindex),
    .data_pointer_i(XMOVE_DATA_POINTER_I),
    .xram_page_field_i(xram_page_reg),
    .addr_o(XMOVE_ADDR_O)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Access shapes shared by the properties below
  sequence s_page_write;
    in_sfr && ACC_WRITE_I && !ACC_BIT_I && ACC_ADDR_I == SFRPX_ADDR_PAGE_SEL;
  endsequence
  sequence s_page_read;
    in_sfr && !ACC_WRITE_I && ACC_ADDR_I == SFRPX_ADDR_PAGE_SEL;
  endsequence
  sequence s_xpage_write;
    in_sfr && ACC_WRITE_I && !ACC_BIT_I && ACC_ADDR_I == SFRPX_ADDR_XRAM_PAGE
    && page_sel_reg == SFRPX_PAGE_DEFAULT;
  endsequence
  sequence s_xpage_read;
    in_sfr && !ACC_WRITE_I && ACC_ADDR_I == SFRPX_ADDR_XRAM_PAGE
    && page_sel_reg == SFRPX_PAGE_DEFAULT;
  endsequence

  // XRAM page register
  a_reserved_bits_zero: assert property ( // [RULE1]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    hit_reg && $past(ACC_ADDR_I) == SFRPX_ADDR_XRAM_PAGE
    |-> RDATA_O[7:4] == 4'h0)
    else $error("xram page upper bits not zero");
  a_xpage_readback: assert property ( // [RULE1]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    s_xpage_write ##1 s_xpage_read
    |=> RDATA_O == {4'h0, $past(ACC_WDATA_I[3:0], 2)})
    else $error("xram page write not read back");
  a_xpage_write_land: assert property ( // [RULE4]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    s_xpage_write
    |=> xram_page_reg == $past(ACC_WDATA_I[3:0]))
    else $error("xram page write lost");
  a_xpage_read_hit: assert property ( // [RULE4]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    s_xpage_read
    |=> RDATA_HIT_O && RDATA_O == {4'h0, $past(xram_page_reg)})
    else $error("xram page read wrong");
  a_xpage_hold: assert property ( // [RULE4]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    !(in_sfr && ACC_WRITE_I && !ACC_BIT_I && ACC_ADDR_I == SFRPX_ADDR_XRAM_PAGE
    && page_sel_reg == SFRPX_PAGE_DEFAULT)
    |=> $stable(xram_page_reg))
    else $error("xram page changed without a write");
  a_xpage_refused: assert property ( // [RULE11]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    in_sfr && ACC_WRITE_I && ACC_ADDR_I == SFRPX_ADDR_XRAM_PAGE && page_sel_reg != SFRPX_PAGE_DEFAULT
    |=> $stable(xram_page_reg))
    else $error("xram page written from another page");
  a_bit_write_dropped: assert property ( // [RULE6]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    in_sfr && ACC_WRITE_I && ACC_BIT_I
    |=> $stable(xram_page_reg) && $stable(SFR_PAGE_O))
    else $error("bit write changed a byte register");

  // Page select
  a_reset_clear: assert property ( // [RULE4] [RULE16]
    @(posedge CLOCK_I)
    !RST_N_I
    |=> SFR_PAGE_O == SFRPX_PAGE_SEL_RESET && !RDATA_HIT_O && RDATA_O == 8'h00
    && {4'h0, xram_page_reg} == SFRPX_XRAM_PAGE_RESET)
    else $error("reset did not clear the registers");
  a_page_next_access: assert property ( // [RULE17] [RULE8]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    s_page_write
    |=> SFR_PAGE_O == $past(ACC_WDATA_I))
    else $error("page select not applied next cycle");
  a_page_read_back: assert property ( // [RULE16]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    s_page_read
    |=> RDATA_HIT_O && RDATA_O == $past(SFR_PAGE_O))
    else $error("page select read wrong");
  a_page_hold: assert property ( // [RULE9]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    !(in_sfr && ACC_WRITE_I && !ACC_BIT_I && ACC_ADDR_I == SFRPX_ADDR_PAGE_SEL)
    |=> $stable(SFR_PAGE_O))
    else $error("page changed without a write");

  // Routing
  a_direct_routes_sfr: assert property ( // [RULE5]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    ACC_VALID_I && ACC_DIRECT_I && ACC_ADDR_I >= SFRPX_SFR_BASE
    |-> SFR_SEL_O && !IRAM_SEL_O)
    else $error("direct upper access not routed to registers");
  a_low_direct_ram: assert property ( // [RULE5]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    ACC_VALID_I && ACC_DIRECT_I && ACC_ADDR_I < SFRPX_SFR_BASE
    |-> IRAM_SEL_O && !SFR_SEL_O)
    else $error("direct lower access not routed to ram");
  a_idle_no_select: assert property ( // [RULE5]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    !ACC_VALID_I
    |-> !SFR_SEL_O && !IRAM_SEL_O)
    else $error("select without an access");
  a_indirect_routes_ram: assert property ( // [RULE15]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    ACC_VALID_I && !ACC_DIRECT_I
    |-> IRAM_SEL_O && !SFR_SEL_O)
    else $error("indirect access reached registers");

  // Bit access
  a_bit_nibble: assert property ( // [RULE6]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    in_sfr && ACC_ADDR_I[2:0] != 3'h0
    |-> !BIT_OK_O)
    else $error("bit access allowed on wrong nibble");
  a_bit_nibble_ok: assert property ( // [RULE6]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    in_sfr && ACC_ADDR_I[2:0] == 3'h0
    |-> BIT_OK_O)
    else $error("bit access refused on bit nibble");
  a_bit_needs_sfr: assert property ( // [RULE6]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    !in_sfr
    |-> !BIT_OK_O)
    else $error("bit access flagged outside registers");

  // Page decode
  a_common_any_page: assert property ( // [RULE10]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    in_sfr && ACC_ADDR_I == SFRPX_ADDR_PAGE_SEL
    |-> tgt == SFRPX_TGT_ALL)
    else $error("page select not common");
  a_default_page: assert property ( // [RULE9]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    in_sfr && !common && on_pg0 && page_sel_reg == SFRPX_PAGE_DEFAULT
    |-> tgt == SFRPX_TGT_PG0)
    else $error("default page not decoded");
  a_page_f_select: assert property ( // [RULE11]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    in_sfr && on_pgf && !common && page_sel_reg == SFRPX_PAGE_EXTRA
    |-> tgt == SFRPX_TGT_PGF)
    else $error("page f register not reached");
  a_page_f_no_pg0: assert property ( // [RULE11]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    in_sfr && !common && page_sel_reg == SFRPX_PAGE_EXTRA
    |-> tgt != SFRPX_TGT_PG0)
    else $error("page zero register reached from page f");
  a_other_page_none: assert property ( // [RULE8]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    in_sfr && !common && page_sel_reg != SFRPX_PAGE_DEFAULT && page_sel_reg != SFRPX_PAGE_EXTRA
    |-> tgt == SFRPX_TGT_NONE)
    else $error("empty page decoded a register");
  a_hole_reserved: assert property ( // [RULE18]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    in_sfr && !common && !on_pg0 && page_sel_reg == SFRPX_PAGE_DEFAULT
    |-> tgt == SFRPX_TGT_NONE)
    else $error("reserved location decoded");

  // Read data
  a_unmapped_zero: assert property ( // [RULE18]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    !hit_reg
    |-> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  a_no_read_no_hit: assert property ( // [RULE18]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    !(in_sfr && !ACC_WRITE_I)
    |=> !RDATA_HIT_O && RDATA_O == 8'h00)
    else $error("read data without a register read");

  // External move
  a_short_high_byte: assert property ( // [RULE2]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    XMOVE_SHORT_I
    |-> XMOVE_ADDR_O[15:8] == {4'h0, xram_page_reg})
    else $error("short move high byte wrong");
  a_short_sixteen_pages: assert property ( // [RULE3]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    XMOVE_SHORT_I
    |-> XMOVE_ADDR_O[15:12] == 4'h0)
    else $error("short move beyond sixteen pages");
  a_short_low_byte: assert property ( // [RULE13]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    XMOVE_SHORT_I
    |-> XMOVE_ADDR_O[7:0] == (XMOVE_USE_R1_I ? XMOVE_R1_I : XMOVE_R0_I))
    else $error("short move low byte wrong");
  a_long_pointer: assert property ( // [RULE14]
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    !XMOVE_SHORT_I
    |-> XMOVE_ADDR_O == XMOVE_DATA_POINTER_I)
    else $error("long move not from data pointer");

endmodule // sfrpx_top

/* sfrpx_xaddr.sv */
// External-move address former
// Assumes index and pointer values come straight from the core
`timescale 1ns/1ps
module sfrpx_xaddr (
  // Move request
  input wire logic short_form_i,
  input wire logic [7:0] index_i,
  input wire logic [15:0] data_pointer_i,
  input wire logic [3:0] xram_page_field_i,
  // Address
  output logic [15:0] addr_o
);
  import sfrpx_pkg::*;

  always_comb begin
    if (short_form_i) begin
      addr_o = {4'h0, xram_page_field_i, index_i}; // [RULE2] [RULE3] [RULE13]
    end else begin
      addr_o = data_pointer_i; // [RULE14]
    end
  end

endmodule // sfrpx_xaddr

/* test_sfrpx_top.sv */
// Self-checking bench for the register-page decoder
// Assumes sfrpx_pkg and sfrpx_core_model are compiled first
`timescale 1ns/1ps
module test_sfrpx_top;
  import sfrpx_pkg::*;
  logic clock, rst_n, xshort, xr1, valid, direct, write, bt, sel, iram, bit_ok, hit;
  logic [7:0] r0, r1, addr, wdata, page, rdata;
  logic [1:0] tgt;
  logic [15:0] data_pointer, xaddr;
  int bad_count, check_count;

  sfrpx_top u_sfrpx_top (.CLOCK_I(clock), .RST_N_I(rst_n), .ACC_VALID_I(valid), .ACC_DIRECT_I(direct),
    .ACC_WRITE_I(write), .ACC_BIT_I(bt), .ACC_ADDR_I(addr), .ACC_WDATA_I(wdata), .SFR_SEL_O(sel),
    .IRAM_SEL_O(iram), .SFR_TARGET_O(tgt), .SFR_PAGE_O(page), .BIT_OK_O(bit_ok), .RDATA_O(rdata),
    .RDATA_HIT_O(hit), .XMOVE_SHORT_I(xshort), .XMOVE_USE_R1_I(xr1), .XMOVE_R0_I(r0), .XMOVE_R1_I(r1),
    .XMOVE_DATA_POINTER_I(data_pointer), .XMOVE_ADDR_O(xaddr));
  sfrpx_core_model u_sfrpx_core_model (.clock_i(clock), .valid_o(valid), .direct_o(direct),
    .write_o(write), .bit_o(bt), .addr_o(addr), .wdata_o(wdata));

  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic exp_hit);
    u_sfrpx_core_model.access(1'b1, 1'b0, 1'b0, a, 8'h00);
    @(posedge clock);
    #1;
    chk({rdata, 7'h00, hit}, {exp, 7'h00, exp_hit});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_sfrpx_core_model.access(1'b1, 1'b1, 1'b0, a, d);
  endtask

  // Decode flags from the direct flag and the address; target checked only for register accesses
  task automatic dec(input logic dir, input logic [7:0] a, input logic [1:0] exp_tgt);
    logic s;
    s = dir && a >= 8'h80;
    u_sfrpx_core_model.access(dir, 1'b0, 1'b0, a, 8'h00);
    chk({sel, iram, bit_ok}, {s, !s, s && (a[3:0] == 4'h0 || a[3:0] == 4'h8)});
    if (s) chk(tgt, exp_tgt);
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    #100us;
    bad_count++;
    conclude();
  end

  initial begin
    {rst_n, xshort, xr1, r0, r1, data_pointer} = '0;
    bad_count = 0;
    check_count = 0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    #1;
    chk(page, 8'h00);
    rd(8'hA7, 8'h00, 1'b1);
    rd(8'hAA, 8'h00, 1'b1);
    dec(1'b1, 8'hBA, SFRPX_TGT_PG0);
    dec(1'b1, 8'h80, SFRPX_TGT_ALL);
    dec(1'b1, 8'h88, SFRPX_TGT_PG0);
    dec(1'b1, 8'h8F, SFRPX_TGT_PG0);
    dec(1'b1, 8'hB4, SFRPX_TGT_NONE);
    dec(1'b1, 8'h7F, SFRPX_TGT_NONE);
    dec(1'b0, 8'hFF, SFRPX_TGT_NONE);
    wr(8'hAA, 8'hF5);
    rd(8'hAA, 8'h05, 1'b1);
    u_sfrpx_core_model.access(1'b1, 1'b1, 1'b1, 8'hAA, 8'h0A);
    rd(8'hAA, 8'h05, 1'b1);
    @(negedge clock);
    {xshort, xr1, r0, r1, data_pointer} = {1'b1, 1'b1, 8'h12, 8'h34, 16'hBEEF};
    #1;
    chk(xaddr, 16'h0534);
    xr1 = 1'b0;
    #1;
    chk(xaddr, 16'h0512);
    xshort = 1'b0;
    #1;
    chk(xaddr, 16'hBEEF);
    // Extra page entered, used, then page 0x0 restored last
    wr(8'hA7, 8'h0F);
    dec(1'b1, 8'hBA, SFRPX_TGT_PGF);
    chk(page, 8'h0F);
    dec(1'b1, 8'hA7, SFRPX_TGT_ALL);
    dec(1'b1, 8'hAB, SFRPX_TGT_NONE);
    rd(8'hAB, 8'h00, 1'b0);
    wr(8'hAA, 8'h03);
    rd(8'hAA, 8'h00, 1'b0);
    rd(8'hA7, 8'h0F, 1'b1);
    wr(8'hA7, 8'h05);
    dec(1'b1, 8'hBA, SFRPX_TGT_NONE);
    dec(1'b1, 8'hE0, SFRPX_TGT_ALL);
    wr(8'hA7, 8'h00);
    rd(8'hAA, 8'h05, 1'b1);
    dec(1'b1, 8'hBA, SFRPX_TGT_PG0);
    u_sfrpx_core_model.release_bus();
    @(posedge clock);
    #1;
    chk({rdata, 7'h00, hit}, 16'h0000);
    // Reset in mid-run returns both registers to zero
    wr(8'hA7, 8'h0F);
    u_sfrpx_core_model.release_bus();
    chk(page, 8'h0F);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    #1;
    chk(page, 8'h00);
    chk({rdata, 7'h00, hit}, 16'h0000);
    rd(8'hAA, 8'h00, 1'b1);
    conclude();
  end
endmodule // test_sfrpx_top
